// ==== rtl/sp_baud.sv ====
/*
 Baud tick generator: divides the clock by one more than a software divider value.
 Assumes divider written before a timed mode is used.
*/
module sp_baud (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_i,
   // Divider setting.
   input wire logic [15:0] div_i,
   // One-cycle tick.
   output logic tick_o
);
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic wrap;

   // A zero divider ticks on every clock so the tick never stops.
   assign wrap = (cnt_ff >= div_i) || (div_i == 16'h0000);
   assign nxt_cnt = wrap ? 16'h0000 : cnt_ff + 16'h0001;
   assign tick_o = wrap;

   // Free-running counter.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_ff <= 16'h0000;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule

// ==== rtl/sp_pkg.sv ====
/*
 Constants for the serial port: register indices, control bit positions, mode codes and timing.
 Assumes a single 125 MHz clock and a plain strobe register port.
*/
// What this block does
// - Accept a received frame only if done flag clear and filter off or final bit one.
// - On acceptance store final bit, load eight data bits, set receive-done flag.
// - After mid stop bit, receiver watches receive pin for a new falling edge.
// - Mode 3 frames and receives exactly like mode 2; only baud source differs.
// - A write to the serial buffer while the transmitter is idle starts transmission in every mode.
// - Mode 0 receives when done flag clear and enable set, driving shift clock.
// - Modes 1 to 3 receive on incoming start bit while receive enable set.
// - Mode code 00: synchronous eight bits, 4 or 12 clock periods per bit.
// - Mode code 01: ten-bit asynchronous frame timed by the baud tick.
// - Mode code 10: eleven-bit frame with ninth bit, 32 or 64 periods per bit.
// - Mode code 11: eleven-bit frame with ninth bit, timer-derived baud.
package sp_pkg;
   // Register indices on the strobe port.
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_BUF = 2'h1;
   localparam logic [1:0] REG_MASK = 2'h2;
   localparam logic [1:0] REG_DIV = 2'h3;
   // Control register bit positions.
   localparam int B_RX_DONE = 0;
   localparam int B_TX_DONE = 1;
   localparam int B_RX_NINTH = 2;
   localparam int B_TX_NINTH = 3;
   localparam int B_RX_EN = 4;
   localparam int B_FILTER = 5;
   localparam int B_MODE_HIGH = 6;
   localparam int B_MODE_LOW = 7;
   localparam int B_FAST = 8;
   localparam logic [8:0] CTRL_RESET = 9'h000;
   // Mode codes as mode_select_low,mode_select_high.
   localparam logic [1:0] MODE_SYNC = 2'h0;
   localparam logic [1:0] MODE_ASYNC10 = 2'h1;
   localparam logic [1:0] MODE_FIXED11 = 2'h2;
   localparam logic [1:0] MODE_TIMED11 = 2'h3;
   // Clock periods per bit for fixed-rate modes.
   localparam int SYNC_FAST = 4;
   localparam int SYNC_SLOW = 12;
   localparam int FIX_FAST = 32;
   localparam int FIX_SLOW = 64;
   // Timed modes use a sixteen-tick oversample of the baud divider.
   localparam int OVERSAMPLE = 16;
   localparam logic [15:0] DIV_RESET = 16'h0043;
endpackage

// ==== rtl/sp_top.sv ====
/*
 Serial port with four modes: synchronous shift, 10-bit and 11-bit asynchronous frames.
 Assumes a strobe register port on mclk_i and an external device on the serial pins.
*/
module sp_top (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_i,
   // Register port.
   input wire logic [1:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // Serial receive pin, also driven as data in mode 0.
   input wire logic rxd_i,
   output logic rxd_o,
   output logic rxd_oe_o,
   // Serial transmit pin, shift clock in mode 0.
   output logic txd_o,
   // Interrupt.
   output logic irq_o
);
   import sp_pkg::*;

   typedef enum logic [1:0] {SP_IDLE, SP_START, SP_DATA, SP_STOP} sp_state_t;

   logic [8:0] ctrl_ff;
   logic [1:0] mask_ff;
   logic [15:0] div_ff;
   logic [7:0] buf_ff;
   logic [15:0] rdata_ff;
   logic rx_s1_ff;
   logic rx_s2_ff;
   logic rx_prev_ff;
   logic baud_tick;

   // Decode of strobes.
   wire wr_ctrl = wr_i && (addr_i == REG_CTRL);
   wire wr_buf = wr_i && (addr_i == REG_BUF);
   wire wr_mask = wr_i && (addr_i == REG_MASK);
   wire wr_div = wr_i && (addr_i == REG_DIV);
   wire [1:0] mode = {ctrl_ff[B_MODE_LOW], ctrl_ff[B_MODE_HIGH]};
   wire sync_mode = (mode == MODE_SYNC);
   wire ninth_mode = mode[1];
   wire timed_mode = (mode == MODE_ASYNC10) || (mode == MODE_TIMED11);

   sp_baud u_baud (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .div_i(div_ff),
      .tick_o(baud_tick)
   );

   // Period of one oversample slot, one sixteenth of a bit time.
   logic [6:0] slot_len;
   assign slot_len = ctrl_ff[B_FAST] ? 7'(FIX_FAST / OVERSAMPLE) : 7'(FIX_SLOW / OVERSAMPLE);
   logic [6:0] slot_ff;
   wire slot_end = (slot_ff + 7'h01 >= slot_len);
   wire os_tick = timed_mode ? baud_tick : slot_end;
   wire [6:0] sync_len = ctrl_ff[B_FAST] ? 7'(SYNC_FAST) : 7'(SYNC_SLOW);

   // Fixed-rate slot counter.
   always_ff @(posedge mclk_i) begin
      if (rst_i || slot_end) begin
         slot_ff <= 7'h00;
      end else begin
         slot_ff <= slot_ff + 7'h01;
      end
   end

   // Pin synchroniser; only the second stage and its one-cycle delayed copy feed logic.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rx_s1_ff <= 1'b1;
         rx_s2_ff <= 1'b1;
         rx_prev_ff <= 1'b1;
      end else begin
         rx_s1_ff <= rxd_i;
         rx_s2_ff <= rx_s1_ff;
         rx_prev_ff <= rx_s2_ff;
      end
   end
   wire rx_fall = rx_prev_ff && !rx_s2_ff;

   // Transmitter: async frame or mode 0 shift, launched by a buffer write.
   sp_state_t tx_st_ff;
   logic [8:0] tx_sh_ff;
   logic [3:0] tx_bits_ff;
   logic [3:0] tx_os_ff;
   logic [6:0] tx_cnt_ff;
   logic txd_ff;
   logic tx_fin;
   logic [6:0] tx_slot_ff;

   // The transmitter keeps its own slot phase, restarted by each launch, so that the start
   // bit lasts a whole bit time in the fixed-rate modes. Sharing the receiver's free-running
   // phase would cut the start bit short by up to one slot. The timed modes still share the
   // baud divider, so their start bit may be short by up to one divider period.
   wire tx_launch = wr_buf && tx_st_ff == SP_IDLE;
   wire tx_slot_end = (tx_slot_ff + 7'h01 >= slot_len);
   wire tx_tick = timed_mode ? baud_tick : tx_slot_end;
   wire tx_os_end = tx_tick && (tx_os_ff == 4'hF);

   // Transmit slot counter.
   always_ff @(posedge mclk_i) begin
      if (rst_i || tx_launch || tx_slot_end) begin
         tx_slot_ff <= 7'h00;
      end else begin
         tx_slot_ff <= tx_slot_ff + 7'h01;
      end
   end
   wire [3:0] tx_nbits = ninth_mode ? 4'h9 : 4'h8;

   // Mode 0 shift clock: low for the first half of each bit; data change one clock before
   // it falls, so they are settled long before the rising edge on which the far side samples.
   logic sclk_ff;
   logic rx0_act_ff;
   logic [3:0] rx0_bits_ff;
   logic [6:0] rx0_cnt_ff;
   logic [7:0] rx0_sh_ff;
   logic rx0_fin;
   wire half_cnt = (tx_cnt_ff == (sync_len >> 1));
   wire full_cnt = (tx_cnt_ff == sync_len - 7'h01);

   always_ff @(posedge mclk_i) begin
      tx_fin <= 1'b0;
      if (rst_i) begin
         tx_st_ff <= SP_IDLE;
         tx_sh_ff <= 9'h1FF;
         tx_bits_ff <= 4'h0;
         tx_os_ff <= 4'h0;
         tx_cnt_ff <= 7'h00;
         txd_ff <= 1'b1;
         sclk_ff <= 1'b1;
      end else if (wr_buf && tx_st_ff == SP_IDLE) begin
         tx_sh_ff <= {ctrl_ff[B_TX_NINTH], wdata_i[7:0]};
         tx_bits_ff <= 4'h0;
         tx_os_ff <= 4'h0;
         tx_cnt_ff <= 7'h00;
         tx_st_ff <= sync_mode ? SP_DATA : SP_START;
         txd_ff <= sync_mode ? 1'b1 : 1'b0;
      end else if (sync_mode && tx_st_ff == SP_DATA) begin
         tx_cnt_ff <= full_cnt ? 7'h00 : tx_cnt_ff + 7'h01;
         if (tx_cnt_ff == 7'h00) begin
            sclk_ff <= 1'b0;
         end
         if (half_cnt) begin
            sclk_ff <= 1'b1;
         end
         if (full_cnt) begin
            tx_sh_ff <= {1'b1, tx_sh_ff[8:1]};
            tx_bits_ff <= tx_bits_ff + 4'h1;
            if (tx_bits_ff == 4'h7) begin
               tx_st_ff <= SP_IDLE;
               tx_fin <= 1'b1;
            end
         end
      end else if (tx_st_ff != SP_IDLE && !sync_mode) begin
         if (tx_tick) begin
            tx_os_ff <= tx_os_ff + 4'h1;
         end
         if (tx_os_end) begin
            unique case (tx_st_ff)
               SP_START: begin
                  tx_st_ff <= SP_DATA;
                  txd_ff <= tx_sh_ff[0];
               end
               SP_DATA: begin
                  tx_bits_ff <= tx_bits_ff + 4'h1;
                  tx_sh_ff <= {1'b1, tx_sh_ff[8:1]};
                  if (tx_bits_ff + 4'h1 == tx_nbits) begin
                     tx_st_ff <= SP_STOP;
                     txd_ff <= 1'b1;
                  end else begin
                     txd_ff <= tx_sh_ff[1];
                  end
               end
               SP_STOP: begin
                  tx_st_ff <= SP_IDLE;
                  tx_fin <= 1'b1;
               end
               default: tx_st_ff <= SP_IDLE;
            endcase
         end
      end else if (!rx0_act_ff) begin
         sclk_ff <= 1'b1;
      end
   end

   // Mode 0 receiver: starts when done flag clear and enable set, shares the shift clock.
   // The done flag lands one cycle after the finish pulse, so the pulse itself also blocks
   // a restart that would otherwise slip into that gap.
   wire rx0_go = sync_mode && !rx0_act_ff && !rx0_fin && !ctrl_ff[B_RX_DONE]
                 && ctrl_ff[B_RX_EN] && tx_st_ff == SP_IDLE;
   // At four clocks per bit the far side has two low clocks to answer, which the two-flop
   // pin synchroniser leaves no room for; the slow rate is the safe one for reception.
   wire rx0_full = (rx0_cnt_ff == sync_len - 7'h01);
   wire rx0_half = (rx0_cnt_ff == (sync_len >> 1) - 7'h01);
   logic rx0_clk_ff;
   always_ff @(posedge mclk_i) begin
      rx0_fin <= 1'b0;
      if (rst_i || !sync_mode) begin
         rx0_act_ff <= 1'b0;
         rx0_bits_ff <= 4'h0;
         rx0_cnt_ff <= 7'h00;
         rx0_sh_ff <= 8'h00;
         rx0_clk_ff <= 1'b1;
      end else if (rx0_go) begin
         rx0_act_ff <= 1'b1;
         rx0_bits_ff <= 4'h0;
         rx0_cnt_ff <= 7'h00;
         rx0_clk_ff <= 1'b0; // The first bit gets a full half bit of low clock too.
      end else if (rx0_act_ff) begin
         rx0_cnt_ff <= rx0_full ? 7'h00 : rx0_cnt_ff + 7'h01;
         rx0_clk_ff <= (rx0_cnt_ff >= (sync_len >> 1) - 7'h01) && !rx0_full;
         if (rx0_half) begin
            rx0_sh_ff <= {rx_s2_ff, rx0_sh_ff[7:1]};
         end
         if (rx0_full) begin
            rx0_bits_ff <= rx0_bits_ff + 4'h1;
            if (rx0_bits_ff == 4'h7) begin
               rx0_act_ff <= 1'b0;
               rx0_fin <= 1'b1;
               rx0_clk_ff <= 1'b1; // No stray falling edge after the last bit.
            end
         end
      end else begin
         rx0_clk_ff <= 1'b1;
      end
   end

   // Asynchronous receiver with sixteen-slot oversampling, sampling at slot 8.
   sp_state_t rx_st_ff;
   logic [3:0] rx_os_ff;
   logic [3:0] rx_bits_ff;
   logic [8:0] rx_sh_ff;
   logic rx_fin;
   logic [7:0] rx_data;
   logic rx_final;
   wire rx_mid = os_tick && (rx_os_ff == 4'h7);
   always_ff @(posedge mclk_i) begin
      rx_fin <= 1'b0;
      if (rst_i || sync_mode) begin
         rx_st_ff <= SP_IDLE;
         rx_os_ff <= 4'h0;
         rx_bits_ff <= 4'h0;
         rx_sh_ff <= 9'h000;
      end else begin
         if (os_tick) begin
            rx_os_ff <= rx_os_ff + 4'h1;
         end
         unique case (rx_st_ff)
            SP_IDLE: begin
               if (rx_fall && ctrl_ff[B_RX_EN]) begin
                  rx_st_ff <= SP_START;
                  rx_os_ff <= 4'h0;
               end
            end
            SP_START: begin
               if (rx_mid) begin
                  rx_st_ff <= rx_s2_ff ? SP_IDLE : SP_DATA; // False start rejected.
                  rx_bits_ff <= 4'h0;
               end
            end
            SP_DATA: begin
               if (rx_mid) begin
                  rx_sh_ff <= {rx_s2_ff, rx_sh_ff[8:1]};
                  rx_bits_ff <= rx_bits_ff + 4'h1;
                  if (rx_bits_ff + 4'h1 == tx_nbits) begin
                     rx_st_ff <= SP_STOP;
                  end
               end
            end
            SP_STOP: begin
               if (rx_mid) begin
                  rx_fin <= 1'b1;
                  rx_st_ff <= SP_IDLE;
               end
            end
            default: rx_st_ff <= SP_IDLE;
         endcase
      end
   end

   // Frame content: eleven-bit frames carry nine data bits, the final bit is the ninth.
   assign rx_data = ninth_mode ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
   assign rx_final = ninth_mode ? rx_sh_ff[8] : rx_s2_ff;
   wire accept_async = rx_fin && !ctrl_ff[B_RX_DONE]
                       && (!ctrl_ff[B_FILTER] || rx_final);
   wire accept = accept_async || rx0_fin;

   // Control register; hardware sets win over software clears.
   logic [8:0] nxt_ctrl;
   always_comb begin
      nxt_ctrl = wr_ctrl ? wdata_i[8:0] : ctrl_ff;
      if (accept) begin
         nxt_ctrl[B_RX_DONE] = 1'b1;
         nxt_ctrl[B_RX_NINTH] = sync_mode ? ctrl_ff[B_RX_NINTH] : rx_final;
      end
      if (tx_fin) begin
         nxt_ctrl[B_TX_DONE] = 1'b1;
      end
   end

   // Register storage.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ctrl_ff <= CTRL_RESET;
         mask_ff <= 2'h0;
         div_ff <= DIV_RESET;
         buf_ff <= 8'h00;
      end else begin
         ctrl_ff <= nxt_ctrl;
         if (wr_mask) begin
            mask_ff <= wdata_i[1:0];
         end
         if (wr_div) begin
            div_ff <= wdata_i;
         end
         if (accept) begin
            buf_ff <= sync_mode ? rx0_sh_ff : rx_data;
         end
      end
   end

   // Read data one cycle after the strobe, zero otherwise.
   logic [15:0] rd_mux;
   always_comb begin
      unique case (addr_i)
         REG_CTRL: rd_mux = {7'h00, ctrl_ff};
         REG_BUF: rd_mux = {8'h00, buf_ff};
         REG_MASK: rd_mux = {14'h0000, mask_ff};
         REG_DIV: rd_mux = div_ff;
      endcase
   end
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_ff <= 16'h0000;
      end else begin
         rdata_ff <= rd_i ? rd_mux : 16'h0000;
      end
   end
   assign rdata_o = rdata_ff;

   // Pins: mode 0 drives the shift clock on transmit and receive, and data only on transmit.
   assign txd_o = sync_mode ? (sclk_ff & rx0_clk_ff) : txd_ff;
   assign rxd_o = tx_sh_ff[0];
   assign rxd_oe_o = sync_mode && tx_st_ff == SP_DATA;
   assign irq_o = |(ctrl_ff[1:0] & mask_ff);
endmodule

// ==== testbench/sp_chk_sva.sv ====
/*
 Checker for the serial port: shadows the settings from register writes.
 Assumes it is bound to sp_top and sees only its ports.
*/
module sp_chk
   import sp_pkg::*;
(
   // Watched ports.
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [1:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic rxd_i,
   input wire logic rxd_o,
   input wire logic rxd_oe_o,
   input wire logic txd_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] mode_ff;
   logic [1:0] mask_ff;
   logic fast_ff;
   logic [9:0] lo_ff;
   logic [7:0] hi_ff;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   // Shadow settings take effect one cycle after the write, as in the block.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         mode_ff <= 2'h0;
         mask_ff <= 2'h0;
         fast_ff <= 1'b0;
         lo_ff <= 10'h000;
         hi_ff <= 8'h00;
      end else begin
         if (wr_i && addr_i == REG_CTRL) begin
            mode_ff <= wdata_i[7:6];
            fast_ff <= wdata_i[B_FAST];
         end
         if (wr_i && addr_i == REG_MASK) mask_ff <= wdata_i[1:0];
         lo_ff <= txd_o ? 10'h000 : lo_ff + 10'h001;
         hi_ff <= !txd_o ? 8'h00 : (hi_ff == 8'hFF ? hi_ff : hi_ff + 8'h01);
      end
   end

   chk_reset_idle: assert property ($fell(rst_i) |-> txd_o && !rxd_oe_o && !irq_o)
      else $error("outputs not idle after reset");
   chk_rdata_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data outside its cycle");
   chk_read_mask: assert property ($past(rd_i) && $past(addr_i) == REG_MASK
      |-> rdata_o[1:0] == $past(mask_ff)) else $error("mask read wrong");
   chk_irq_masked: assert property (irq_o |-> mask_ff != 2'h0 || $past(mask_ff) != 2'h0)
      else $error("interrupt with all sources masked");
   chk_oe_sync: assert property (rxd_oe_o |-> mode_ff == MODE_SYNC)
      else $error("receive pin driven outside mode 0");
   chk_sync_half: assert property ($rose(txd_o) && mode_ff == MODE_SYNC
      |-> lo_ff == (fast_ff ? 10'h002 : 10'h006)) else $error("shift clock low time");
   chk_bit_width: assert property ($rose(txd_o) && mode_ff == MODE_FIXED11
      |-> lo_ff != 10'h000 && (fast_ff ? lo_ff[4:0] : lo_ff[5:0]) == 6'h00)
      else $error("low run not whole bits");
   chk_tx_start: assert property (wr_i && addr_i == REG_BUF && mode_ff != MODE_SYNC
      && hi_ff == 8'hFF |=> !txd_o) else $error("buffer write did not start frame");
   chk_sync_rx: assert property (wr_i && addr_i == REG_CTRL && wdata_i[7:6] == 2'h0
      && wdata_i[B_RX_EN] && !wdata_i[B_RX_DONE] |-> ##[2:20] !txd_o)
      else $error("mode 0 reception gave no shift clock");
   cover property ($rose(irq_o));
   cover property ($rose(txd_o) && mode_ff == MODE_SYNC);
   cover property ($fell(txd_o) && mode_ff == MODE_FIXED11);
endmodule

bind sp_top sp_chk chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .rxd_o(rxd_o),
   .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o));

// ==== testbench/sp_ext.sv ====
/*
 External serial device: sends frames, captures frames and feeds mode 0 data.
 Assumes the bench clock and a pulled-up receive line.
*/
module sp_ext (
   // Clock.
   input wire logic mclk_i,
   // Device transmit pin, the shift clock in mode 0.
   input wire logic txd_i,
   // Line toward the device receive pin.
   output logic rxd_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // The line has a pull-up, so released it reads high.
   initial rxd_o = 1'b1;

   // Start bit, data low bit first, stop bit; per is clocks per bit.
   task send(input logic [8:0] d, input int nb, input int per);
      int i;
      @(posedge mclk_i);
      rxd_o <= 1'b0;
      repeat (per) @(posedge mclk_i);
      for (i = 0; i < nb; i++) begin
         rxd_o <= d[i];
         repeat (per) @(posedge mclk_i);
      end
      rxd_o <= 1'b1;
      repeat (per) @(posedge mclk_i);
   endtask

   // Samples bits mid-way; unknown marks a missing start or a bad stop.
   task grab(input int per, output logic [8:0] d);
      int i;
      d = 'x;
      for (i = 0; i < 2000 && txd_i; i++) @(posedge mclk_i);
      if (txd_i) return;
      repeat (per / 2) @(posedge mclk_i);
      for (i = 0; i < 9; i++) begin
         repeat (per) @(posedge mclk_i);
         d[i] = txd_i;
      end
      repeat (per) @(posedge mclk_i);
      if (!txd_i) d = 'x;
   endtask

   // A new bit follows each falling shift clock edge and holds a whole bit.
   task shift(input logic [7:0] d);
      int i, n;
      for (i = 0; i < 8; i++) begin
         for (n = 0; n < 100 && txd_i; n++) @(posedge mclk_i);
         rxd_o <= d[i];
         for (n = 0; n < 100 && !txd_i; n++) @(posedge mclk_i);
      end
      rxd_o <= 1'b1;
   endtask
endmodule

// ==== testbench/sp_top_tb_top.sv ====
/*
 Bench for the serial port: register tasks, one task per scenario.
 Assumes sp_top, the sp_ext device model and the bound checker.
*/
module sp_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sp_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [15:0] rdata;
   logic drv_rxd, drv_oe, txd, irq, ext_rxd;
   wire rxd_w;
   int fail_count = 0;
   int num_checks = 0;

   // Clock of 8 ns; the pin level follows whoever drives it.
   always #4 mclk = ~mclk;
   assign rxd_w = drv_oe ? drv_rxd : ext_rxd;

   sp_top dut_u (.mclk_i(mclk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
      .rd_i(rd_s), .rdata_o(rdata), .rxd_i(rxd_w), .rxd_o(drv_rxd), .rxd_oe_o(drv_oe),
      .txd_o(txd), .irq_o(irq));
   sp_ext ext_u (.mclk_i(mclk), .txd_i(txd), .rxd_o(ext_rxd));

   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge mclk);
      wr_s <= 1'b0;
   endtask
   // Read data are only valid in the cycle after the strobe.
   task rchk(input logic [1:0] a, input logic [15:0] exp);
      @(posedge mclk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge mclk);
      rd_s <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task s_reset;
      rchk(REG_CTRL, {7'h00, CTRL_RESET});
      rchk(REG_DIV, DIV_RESET);
      chk({14'h0000, txd, irq}, 16'h0002);
   endtask
   // Mode 2 fast transmit with ninth bit, then the masked interrupt and its clearing.
   task s_tx;
      logic [8:0] f;
      int n;
      wr(REG_MASK, 16'h0002);
      rchk(REG_MASK, 16'h0002);
      wr(REG_CTRL, 16'h0188);
      wr(REG_BUF, 16'h00A5);
      ext_u.grab(32, f);
      chk({7'h00, f}, 16'h01A5);
      for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge mclk);
      rchk(REG_CTRL, 16'h018A);
      chk({15'h0000, irq}, 16'h0001);
      wr(REG_CTRL, 16'h0188);
      repeat (2) @(posedge mclk);
      chk({15'h0000, irq}, 16'h0000);
   endtask
   // Acceptance, discard while full, filter, and a frame right after another.
   task s_rx;
      wr(REG_CTRL, 16'h0190);
      ext_u.send(9'h13C, 9, 32);
      rchk(REG_BUF, 16'h003C);
      rchk(REG_CTRL, 16'h0195);
      chk({15'h0000, irq}, 16'h0000);
      ext_u.send(9'h0C3, 9, 32);
      rchk(REG_BUF, 16'h003C);
      wr(REG_CTRL, 16'h01B0);
      ext_u.send(9'h055, 9, 32);
      rchk(REG_CTRL, 16'h01B0);
      ext_u.send(9'h1AA, 9, 32);
      rchk(REG_BUF, 16'h00AA);
      rchk(REG_CTRL, 16'h01B5);
   endtask
   // Timed modes 1 and 3 with a divider of one, giving 32 clocks per bit.
   task s_timed;
      int i;
      wr(REG_DIV, 16'h0001);
      for (i = 0; i < 2; i++) begin
         wr(REG_CTRL, i ? 16'h00D0 : 16'h0050);
         ext_u.send(i ? 9'h0A6 : 9'h05A, i ? 9 : 8, 32);
         rchk(REG_BUF, i ? 16'h00A6 : 16'h005A);
         rchk(REG_CTRL, i ? 16'h00D1 : 16'h0055);
      end
   endtask
   // Mode 0 slow reception; one bit time lets the last bit land.
   task s_sync;
      fork
         wr(REG_CTRL, 16'h0010);
         ext_u.shift(8'h96);
      join
      repeat (12) @(posedge mclk);
      rchk(REG_BUF, 16'h0096);
      rchk(REG_CTRL, 16'h0011);
   endtask
   // Mode 0 fast transmit: data on the receive pin, taken at each rising shift clock.
   task s_sync_tx;
      logic [7:0] got;
      logic prev;
      int i;
      int n;
      got = 8'h00;
      prev = 1'b1;
      i = 0;
      wr(REG_CTRL, 16'h0100);
      wr(REG_BUF, 16'h005C);
      for (n = 0; n < 200 && i < 8; n++) begin
         @(posedge mclk);
         if (!prev && txd) begin
            got[i] = rxd_w;
            i++;
         end
         prev = txd;
      end
      chk({8'h00, got}, 16'h005C);
      repeat (2) @(posedge mclk);
      rchk(REG_CTRL, 16'h0102);
   endtask

   // Main sequence after ten reset cycles.
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      s_reset;
      s_tx;
      s_rx;
      s_timed;
      s_sync;
      s_sync_tx;
      complete_run;
   end
   // A hang is cut short and counted as a mismatch.
   initial begin
      #400000;
      fail_count++;
      complete_run;
   end
endmodule
